// [inc/io_exp_pkg.sv]
package io_exp_pkg;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int unsigned PORT_W    = 8;
    localparam int unsigned STRAP_W   = 3;
    localparam int unsigned FIXED_W   = 4;
    localparam logic [3:0] BIT_CNT_FULL = 4'h8;
    localparam logic [3:0] BIT_CNT_LAST = 4'h7;
    localparam logic [3:0] BIT_CNT_RST  = 4'h0;
    // core cycles for released lines to pass the pin synchroniser
    localparam logic [2:0] SETTLE_CYC   = 3'h5;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_RESET  = 8'hff;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [1:0] BUS_RESET   = 2'h3;
    localparam logic [2:0] STRAP_RESET = 3'h0;

    // arbitrary neutral value for the fixed upper address part
    localparam logic [3:0] FIXED_ADDR_DEFAULT = 4'h5;

    // ----------------------------------------------------------------
    // link state machine
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR_DATA  = 3'b011,
        ST_WR_ACK   = 3'b100,
        ST_RD_DATA  = 3'b101,
        ST_RD_ACK   = 3'b110
    } link_state_t;

endpackage : io_exp_pkg

// [hdl/sync3.sv]
`timescale 1ns/10ps
module sync3 #(
    parameter int unsigned   W    = 1,
    parameter logic [W-1:0]  INIT = '0
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [W-1:0]  d,
    output logic      [W-1:0]  q
);
    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;
    logic [W-1:0] ff3_q;
    logic [W-1:0] q_d;

    // ----------------------------------------------------------------
    // accept a change only once stages two and three agree
    // ----------------------------------------------------------------
    always_comb begin
        q_d = q;
        if (ff2_q == ff3_q) begin
            q_d = ff3_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ff1_q <= INIT;
            ff2_q <= INIT;
            ff3_q <= INIT;
            q     <= INIT;
        end else begin
            ff1_q <= d;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
            q     <= q_d;
        end
    end
endmodule : sync3

// [hdl/io_expander.sv]
`timescale 1ns/10ps
module io_expander
    import io_exp_pkg::*;
#(
    parameter logic [3:0] FIXED_ADDR = FIXED_ADDR_DEFAULT
) (
    input  wire logic        core_clk,
    input  wire logic        link_clk,
    input  wire logic        rstn,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        strap_addr_bit0,
    input  wire logic        strap_addr_bit1,
    input  wire logic        strap_addr_bit2,
    input  wire logic [7:0]  port_line_in,
    output logic      [7:0]  port_line_out,
    output logic      [7:0]  port_line_oe,
    output logic             attention_out_low_out,
    output logic             attention_out_low_oe
);

    // ----------------------------------------------------------------
    // link domain: synchronised bus and straps
    // ----------------------------------------------------------------
    logic [1:0]  bus_s;
    logic [2:0]  strap_s;
    logic        scl_s;
    logic        sda_s;
    logic        scl_prev_q;
    logic        sda_prev_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;

    sync3 #(.W(2), .INIT(BUS_RESET)) u_bus_sync (
        .clk  (link_clk),
        .rstn (rstn),
        .d    ({scl_in, sda_in}),
        .q    (bus_s)
    );

    sync3 #(.W(STRAP_W), .INIT(STRAP_RESET)) u_strap_sync (
        .clk  (link_clk),
        .rstn (rstn),
        .d    ({strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}),
        .q    (strap_s)
    );

    assign scl_s    = bus_s[1];
    assign sda_s    = bus_s[0];
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    // data moving under a high clock is never a data bit
    assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_cond  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ----------------------------------------------------------------
    // link domain: port snapshot received from core
    // ----------------------------------------------------------------
    logic        snap_req_q;
    logic [0:0]  snap_req_s;
    logic        snap_ack_q;
    logic        snap_ack_d;
    logic [7:0]  rd_snap_q;
    logic [7:0]  rd_snap_d;
    logic [7:0]  core_snap_q;

    sync3 #(.W(1), .INIT(1'h0)) u_snap_sync (
        .clk  (link_clk),
        .rstn (rstn),
        .d    (snap_req_q),
        .q    (snap_req_s)
    );

    always_comb begin
        snap_ack_d = snap_ack_q;
        rd_snap_d  = rd_snap_q;
        // core holds its snapshot still until this ack returns
        if (snap_req_s[0] != snap_ack_q) begin
            rd_snap_d  = core_snap_q;
            snap_ack_d = snap_req_s[0];
        end
    end

    // ----------------------------------------------------------------
    // link domain: slave state machine
    // ----------------------------------------------------------------
    link_state_t state_q;
    link_state_t state_d;
    logic [3:0]  cnt_q;
    logic [3:0]  cnt_d;
    logic [7:0]  shift_q;
    logic [7:0]  shift_d;
    logic        rw_q;
    logic        rw_d;
    logic        nack_q;
    logic        nack_d;
    logic        sda_oe_d;
    logic [7:0]  wdata_q;
    logic [7:0]  wdata_d;
    logic        wr_tgl_q;
    logic        wr_tgl_d;
    logic        clr_tgl_q;
    logic        clr_tgl_d;
    logic        addr_hit;

    assign addr_hit = (shift_q[7:1] == {FIXED_ADDR, strap_s});

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        shift_d   = shift_q;
        rw_d      = rw_q;
        nack_d    = nack_q;
        sda_oe_d  = sda_oe;
        wdata_d   = wdata_q;
        wr_tgl_d  = wr_tgl_q;
        clr_tgl_d = clr_tgl_q;
        if (stop_cond) begin
            // a partial byte is dropped, the latch keeps the last ack
            state_d  = ST_IDLE;
            sda_oe_d = 1'b0;
        end else if (start_cond) begin
            state_d  = ST_ADDR;
            cnt_d    = BIT_CNT_RST;
            sda_oe_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    sda_oe_d = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d   = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BIT_CNT_FULL) begin
                        if (addr_hit) begin
                            rw_d     = shift_q[0];
                            sda_oe_d = 1'b1;
                            state_d  = ST_ADDR_ACK;
                        end else begin
                            state_d  = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_rise && rw_q) begin
                        shift_d   = rd_snap_q;
                        clr_tgl_d = ~clr_tgl_q;
                    end else if (scl_fall) begin
                        // ack held low until the clock falls again
                        cnt_d = BIT_CNT_RST;
                        if (rw_q) begin
                            sda_oe_d = ~shift_q[7];
                            state_d  = ST_RD_DATA;
                        end else begin
                            sda_oe_d = 1'b0;
                            state_d  = ST_WR_DATA;
                        end
                    end
                end
                ST_WR_DATA: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d   = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BIT_CNT_FULL) begin
                        sda_oe_d = 1'b1;
                        state_d  = ST_WR_ACK;
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        // commit only once the ack slot is complete
                        wdata_d   = shift_q;
                        wr_tgl_d  = ~wr_tgl_q;
                        clr_tgl_d = ~clr_tgl_q;
                        sda_oe_d  = 1'b0;
                        cnt_d     = BIT_CNT_RST;
                        state_d   = ST_WR_DATA;
                    end
                end
                ST_RD_DATA: begin
                    if (scl_fall) begin
                        if (cnt_q == BIT_CNT_LAST) begin
                            sda_oe_d = 1'b0;
                            state_d  = ST_RD_ACK;
                        end else begin
                            cnt_d    = cnt_q + 4'h1;
                            shift_d  = {shift_q[6:0], 1'b0};
                            sda_oe_d = ~shift_q[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        nack_d = sda_s;
                        if (!sda_s) begin
                            shift_d   = rd_snap_q;
                            clr_tgl_d = ~clr_tgl_q;
                        end
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            sda_oe_d = 1'b0;
                            state_d  = ST_IDLE;
                        end else begin
                            cnt_d    = BIT_CNT_RST;
                            sda_oe_d = ~shift_q[7];
                            state_d  = ST_RD_DATA;
                        end
                    end
                end
                default: begin
                    sda_oe_d = 1'b0;
                    state_d  = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            snap_ack_q <= 1'b0;
            rd_snap_q  <= PORT_RESET;
            state_q    <= ST_IDLE;
            cnt_q      <= BIT_CNT_RST;
            shift_q    <= SHIFT_RESET;
            rw_q       <= 1'b0;
            nack_q     <= 1'b0;
            sda_oe     <= 1'b0;
            sda_out    <= 1'b0;
            wdata_q    <= PORT_RESET;
            wr_tgl_q   <= 1'b0;
            clr_tgl_q  <= 1'b0;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            snap_ack_q <= snap_ack_d;
            rd_snap_q  <= rd_snap_d;
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            shift_q    <= shift_d;
            rw_q       <= rw_d;
            nack_q     <= nack_d;
            sda_oe     <= sda_oe_d;
            sda_out    <= 1'b0;
            wdata_q    <= wdata_d;
            wr_tgl_q   <= wr_tgl_d;
            clr_tgl_q  <= clr_tgl_d;
        end
    end

    // ----------------------------------------------------------------
    // core domain: pins and events from the link
    // ----------------------------------------------------------------
    logic [7:0]  pins_s;
    logic [2:0]  ev_s;
    logic [2:0]  ev_prev_q;
    logic        wr_evt;
    logic        clr_evt;
    logic        snap_ack_seen;

    sync3 #(.W(PORT_W), .INIT(PORT_RESET)) u_pin_sync (
        .clk  (core_clk),
        .rstn (rstn),
        .d    (port_line_in),
        .q    (pins_s)
    );

    sync3 #(.W(3), .INIT(3'h0)) u_evt_sync (
        .clk  (core_clk),
        .rstn (rstn),
        .d    ({snap_ack_q, clr_tgl_q, wr_tgl_q}),
        .q    (ev_s)
    );

    assign wr_evt        = ev_s[0] ^ ev_prev_q[0];
    assign clr_evt       = ev_s[1] ^ ev_prev_q[1];
    assign snap_ack_seen = ev_s[2];

    // ----------------------------------------------------------------
    // core domain: latch, snapshot and attention
    // ----------------------------------------------------------------
    logic [7:0]  latch_q;
    logic [7:0]  latch_d;
    logic [7:0]  ref_q;
    logic [7:0]  ref_d;
    logic        snap_req_d;
    logic [7:0]  core_snap_d;
    logic        att_d;
    logic [2:0]  settle_q;
    logic [2:0]  settle_d;

    always_comb begin
        latch_d     = latch_q;
        ref_d       = ref_q;
        snap_req_d  = snap_req_q;
        core_snap_d = core_snap_q;
        settle_d    = settle_q;
        if (settle_q != 3'h0) begin
            settle_d = settle_q - 3'h1;
        end
        if (wr_evt) begin
            latch_d  = wdata_q;
            // a released line is not an input edge until it settles
            settle_d = SETTLE_CYC;
        end
        if (clr_evt || wr_evt || settle_q != 3'h0) begin
            ref_d = pins_s;
        end
        // free-running handshake keeps the link copy a few cycles old
        if (snap_ack_seen == snap_req_q) begin
            core_snap_d = pins_s;
            snap_req_d  = ~snap_req_q;
        end
        // only lines latched high act as inputs
        att_d = |((pins_s ^ ref_q) & latch_q);
        if (clr_evt || wr_evt || settle_q != 3'h0) begin
            att_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ev_prev_q             <= 3'h0;
            latch_q               <= PORT_RESET;
            ref_q                 <= PORT_RESET;
            snap_req_q            <= 1'b0;
            core_snap_q           <= PORT_RESET;
            settle_q              <= 3'h0;
            port_line_out         <= 8'h00;
            port_line_oe          <= 8'h00;
            attention_out_low_out <= 1'b0;
            attention_out_low_oe  <= 1'b0;
        end else begin
            ev_prev_q             <= ev_s;
            latch_q               <= latch_d;
            ref_q                 <= ref_d;
            snap_req_q            <= snap_req_d;
            core_snap_q           <= core_snap_d;
            settle_q              <= settle_d;
            port_line_out         <= 8'h00;
            port_line_oe          <= ~latch_d;
            attention_out_low_out <= 1'b0;
            attention_out_low_oe  <= att_d;
        end
    end

endmodule : io_expander

// [dv/io_expander_checker.sv]
`timescale 1ns/10ps
module io_expander_checker (
    input wire logic       core_clk,
    input wire logic       link_clk,
    input wire logic       rstn,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [7:0] port_line_in,
    input wire logic [7:0] port_line_out,
    input wire logic [7:0] port_line_oe,
    input wire logic       attention_out_low_out,
    input wire logic       attention_out_low_oe
);
    // ----------------------------------------------------------------
    // link side
    // ----------------------------------------------------------------
    property p_sda_low_only;
        @(posedge link_clk) disable iff (!rstn) sda_out == 1'b0;
    endproperty
    a_sda_low_only: assert property (p_sda_low_only)
        else $error("data line driven high");
    property p_sda_stable_high;
        @(posedge link_clk) disable iff (!rstn)
            scl_in && $past(scl_in) |-> $stable(sda_oe);
    endproperty
    a_sda_stable_high: assert property (p_sda_stable_high)
        else $error("data drive moved with clock high");
    // drive moves only after a settled clock fall, never near the high phase
    property p_sda_moves_low;
        @(posedge link_clk) disable iff (!rstn)
            $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
    endproperty
    a_sda_moves_low: assert property (p_sda_moves_low)
        else $error("data drive moved outside clock low");
    property p_start_quiet;
        @(posedge link_clk) disable iff (!rstn)
            scl_in && $past(scl_in) && $fell(sda_in) |-> !sda_oe [*8];
    endproperty
    a_start_quiet: assert property (p_start_quiet)
        else $error("data driven right after start");
    property p_stop_quiet;
        @(posedge link_clk) disable iff (!rstn)
            scl_in && $past(scl_in) && $rose(sda_in) |-> !sda_oe [*8];
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("data driven right after stop");
    // ----------------------------------------------------------------
    // port side
    // ----------------------------------------------------------------
    property p_attn_od;
        @(posedge core_clk) disable iff (!rstn) attention_out_low_out == 1'b0;
    endproperty
    a_attn_od: assert property (p_attn_od)
        else $error("attention driven high");
    property p_port_od;
        @(posedge core_clk) disable iff (!rstn) port_line_out == 8'h00;
    endproperty
    a_port_od: assert property (p_port_od)
        else $error("port line driven high");
    property p_attn_inputs_only;
        @(posedge core_clk) disable iff (!rstn)
            $rose(attention_out_low_oe) |-> port_line_oe != 8'hff;
    endproperty
    a_attn_inputs_only: assert property (p_attn_inputs_only)
        else $error("attention with no input line");
    // only while quiet: a change back to the old value may release it
    property p_attn_on_edge;
        @(posedge core_clk) disable iff (!rstn)
            !attention_out_low_oe && $stable(port_line_oe)
            && (|((port_line_in ^ $past(port_line_in)) & ~port_line_oe))
            |-> ##[1:8] attention_out_low_oe;
    endproperty
    a_attn_on_edge: assert property (p_attn_on_edge)
        else $error("input edge raised no attention");
    c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
    c_stop: cover property (@(posedge link_clk) scl_in && $rose(sda_in));
    c_attn: cover property (@(posedge core_clk) $rose(attention_out_low_oe));
endmodule : io_expander_checker

bind io_expander io_expander_checker u_io_expander_checker (
    .core_clk(core_clk), .link_clk(link_clk), .rstn(rstn),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .port_line_in(port_line_in), .port_line_out(port_line_out),
    .port_line_oe(port_line_oe),
    .attention_out_low_out(attention_out_low_out),
    .attention_out_low_oe(attention_out_low_oe)
);

// [dv/bus_master_model.sv]
`timescale 1ns/10ps
module bus_master_model (
    input  wire logic core_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // quarter of a 100 kHz bit, always just after a core edge
    task automatic quarter();
        repeat (25) @(posedge core_clk);
        #1;
    endtask : quarter
    // data only moves with clock low; sampled mid high phase
    task automatic clock_bit(input logic b, output logic seen);
        sda_low = ~b;
        quarter();
        scl = 1'b1;
        quarter();
        seen = sda_wire;
        quarter();
        scl = 1'b0;
        quarter();
    endtask : clock_bit
    // caller only starts on an idle bus
    task automatic start();
        sda_low = 1'b1;
        quarter();
        scl = 1'b0;
        quarter();
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        quarter();
        scl = 1'b1;
        quarter();
        sda_low = 1'b0;
        quarter();
    endtask : stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], seen);
        end
        clock_bit(1'b1, seen);
        ack = ~seen;
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] b, input logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, b[i]);
        end
        clock_bit(~ack, seen);
    endtask : recv_byte
endmodule : bus_master_model

// [dv/tb_io_expander.sv]
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin total_checks++; \
    if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module tb_io_expander;
    import io_exp_pkg::*;
    logic       core_clk;
    logic       link_clk;
    logic       rstn;
    logic       scl;
    logic       sda_low;
    logic       sda_oe;
    logic [2:0] strap;
    logic [7:0] ext_low;
    logic [7:0] port_oe;
    logic       attn_oe;
    int         err_total;
    int         total_checks;
    // open-drain wires with pull-ups
    wire        sda_wire  = ~(sda_oe | sda_low);
    wire  [7:0] port_pins = ~(port_oe | ext_low);

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    io_expander u_io_expander (
        .core_clk(core_clk), .link_clk(link_clk), .rstn(rstn),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(), .sda_oe(sda_oe),
        .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
        .strap_addr_bit2(strap[2]), .port_line_in(port_pins),
        .port_line_out(), .port_line_oe(port_oe),
        .attention_out_low_out(), .attention_out_low_oe(attn_oe)
    );
    bus_master_model u_bus_master_model (
        .core_clk(core_clk), .sda_wire(sda_wire), .scl(scl),
        .sda_low(sda_low)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc
    task automatic write_one(input logic [7:0] d);
        logic ack;
        u_bus_master_model.start();
        u_bus_master_model.send_byte({FIXED_ADDR_DEFAULT, strap, 1'b0}, ack);
        `CHK("address ack", 1'b1, ack)
        u_bus_master_model.send_byte(d, ack);
        `CHK("data ack", 1'b1, ack)
    endtask : write_one
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        wait_cyc(2);
        `CHK("port in reset", 8'h00, port_oe)
        rstn = 1'b1;
        wait_cyc(30);
        `CHK("port after reset", 8'h00, port_oe)
        `CHK("attention after reset", 1'b0, attn_oe)
        `CHK("data idle", 1'b0, sda_oe)
        $display("test_reset done");
    endtask : test_reset
    task automatic test_write();
        logic ack;
        write_one(8'ha5);
        `CHK("port byte 1", 8'h5a, port_oe)
        u_bus_master_model.send_byte(8'h3c, ack);
        `CHK("third byte ack", 1'b1, ack)
        u_bus_master_model.stop();
        `CHK("port byte 2", 8'hc3, port_oe)
        $display("test_write done");
    endtask : test_write
    task automatic test_wrong_addr();
        logic ack;
        u_bus_master_model.start();
        u_bus_master_model.send_byte({FIXED_ADDR_DEFAULT, strap ^ 3'h2, 1'b0},
                                     ack);
        `CHK("foreign address ack", 1'b0, ack)
        u_bus_master_model.send_byte(8'h00, ack);
        `CHK("foreign data ack", 1'b0, ack)
        u_bus_master_model.stop();
        `CHK("port untouched", 8'hc3, port_oe)
        $display("test_wrong_addr done");
    endtask : test_wrong_addr
    task automatic test_early_stop();
        logic seen;
        strap = 3'h3;
        wait_cyc(10);
        write_one(8'hf0);
        for (int i = 0; i < 4; i++) begin
            u_bus_master_model.clock_bit(1'b0, seen);
        end
        u_bus_master_model.stop();
        wait_cyc(20);
        `CHK("port after early stop", 8'h0f, port_oe)
        $display("test_early_stop done");
    endtask : test_early_stop
    task automatic test_read();
        logic       ack;
        logic [7:0] d;
        write_one(8'hff);
        u_bus_master_model.stop();
        ext_low = 8'h96;
        wait_cyc(20);
        `CHK("attention on input edge", 1'b1, attn_oe)
        u_bus_master_model.start();
        u_bus_master_model.send_byte({FIXED_ADDR_DEFAULT, strap, 1'b1}, ack);
        `CHK("read address ack", 1'b1, ack)
        u_bus_master_model.recv_byte(d, 1'b1);
        `CHK("read byte 1", 8'h69, d)
        `CHK("attention cleared by read", 1'b0, attn_oe)
        u_bus_master_model.recv_byte(d, 1'b0);
        `CHK("read byte 2", 8'h69, d)
        `CHK("released after no ack", 1'b0, sda_oe)
        u_bus_master_model.stop();
        ext_low = 8'h10;
        wait_cyc(20);
        `CHK("attention on change", 1'b1, attn_oe)
        ext_low = 8'h96;
        wait_cyc(20);
        `CHK("attention on return", 1'b0, attn_oe)
        $display("test_read done");
    endtask : test_read

    initial begin
        rstn         = 1'b0;
        strap        = 3'h5;
        ext_low      = 8'h00;
        err_total    = 0;
        total_checks = 0;
        test_reset();
        test_write();
        test_wrong_addr();
        test_early_stop();
        test_read();
        test_done();
    end
    // hang guard well beyond the longest scenario
    initial begin
        repeat (100000) @(posedge core_clk);
        err_total++;
        $display("unexpected run length: limit reached");
        test_done();
    end
endmodule : tb_io_expander
